// ==== core/tcr_pkg.sv ====
// Constants, register map and state types for the timer two block.
package tcr_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_MODE = 8'hC9;
  localparam logic [7:0] ADDR_CAP_LOW = 8'hCA;
  localparam logic [7:0] ADDR_CAP_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_EXTERNAL = 6;
  localparam int BIT_RX_CLOCK = 5;
  localparam int BIT_TX_CLOCK = 4;
  localparam int BIT_EXT_ENABLE = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNTER_SEL = 1;
  localparam int BIT_CAPTURE_SEL = 0;
  localparam int BIT_OUT_ENABLE = 1;
  localparam int BIT_DOWN_ENABLE = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // ---------------------------------------------------------------
  // Machine cycle timing
  // ---------------------------------------------------------------
  localparam int OSC_PER_CYCLE = 12;
  localparam logic [3:0] LAST_PHASE = 4'(OSC_PER_CYCLE - 1);
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
  localparam logic [3:0] UPDATE_PHASE = 4'h4;

  typedef struct packed {
    logic [3:0] phase;
    logic sample_strobe;
    logic update_strobe;
    logic state_strobe;
  } tcr_phase_t;

  typedef struct packed {
    logic [1:0] count_sync;
    logic [1:0] trig_sync;
    logic count_sample;
    logic trig_sample;
    logic count_fall;
    logic trig_fall;
  } tcr_pins_t;

  typedef struct packed {
    logic [7:0] control;
    logic out_enable;
    logic down_enable;
    logic [15:0] count;
    logic [15:0] capture;
    logic pending;
    logic [7:0] rdata;
    logic irq;
    logic rx_pulse;
    logic tx_pulse;
  } tcr_state_t;

endpackage

// ==== core/tcr_timing_if.sv ====
// Interface carrying machine-cycle strobes and sampled pin events.
`timescale 1ns/1ps
interface tcr_timing_if;
  logic sample_strobe;
  logic update_strobe;
  logic state_strobe;
  logic count_fall;
  logic trig_fall;
  logic trig_level;

  modport gen (output sample_strobe, output update_strobe,
    output state_strobe);
  modport pins (input sample_strobe, output count_fall, output trig_fall,
    output trig_level);
  modport use_side (input sample_strobe, input update_strobe,
    input state_strobe, input count_fall, input trig_fall,
    input trig_level);
endinterface

// ==== core/tcr_phase_gen.sv ====
// Machine-cycle phase generator producing sample, update and state strobes.
`timescale 1ns/1ps
module tcr_phase_gen
  import tcr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Strobes.
  tcr_timing_if.gen tim
);

  tcr_phase_t s;
  tcr_phase_t next_s;

  // ---------------------------------------------------------------
  // Phase counter
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.phase = (s.phase == LAST_PHASE) ? 4'h0 : s.phase + 4'h1;
    next_s.sample_strobe = (next_s.phase == SAMPLE_PHASE);
    next_s.update_strobe = (next_s.phase == UPDATE_PHASE);
    next_s.state_strobe = next_s.phase[0];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tim.sample_strobe = s.sample_strobe;
  assign tim.update_strobe = s.update_strobe;
  assign tim.state_strobe = s.state_strobe;

endmodule // tcr_phase_gen

// ==== core/tcr_pin_sampler.sv ====
// Synchronises the count and trigger pins and detects sampled falls.
`timescale 1ns/1ps
module tcr_pin_sampler
  import tcr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Raw pins.
  input wire logic count_pin,
  input wire logic trigger_pin,
  // Sampled events.
  tcr_timing_if.pins tim
);

  tcr_pins_t s;
  tcr_pins_t next_s;

  // ---------------------------------------------------------------
  // Synchronise, sample once per machine cycle, compare samples
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.count_sync = {s.count_sync[0], count_pin};
    next_s.trig_sync = {s.trig_sync[0], trigger_pin};
    next_s.count_fall = 1'b0;
    next_s.trig_fall = 1'b0;
    if (tim.sample_strobe) begin
      next_s.count_sample = s.count_sync[1];
      next_s.trig_sample = s.trig_sync[1];
      next_s.count_fall = s.count_sample & ~s.count_sync[1];
      next_s.trig_fall = s.trig_sample & ~s.trig_sync[1];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tim.count_fall = s.count_fall;
  assign tim.trig_fall = s.trig_fall;
  assign tim.trig_level = s.trig_sync[1];

endmodule // tcr_pin_sampler

// ==== core/tcr_timer.sv ====
// Timer two with capture, auto-reload, up/down and baud generation.
`timescale 1ns/1ps
module tcr_timer
  import tcr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESETN,
  // Special function register bus.
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  output logic [7:0] SFR_RDATA,
  // External pins.
  input wire logic COUNT_PIN,
  input wire logic TRIGGER_PIN,
  // Serial port clocking.
  input wire logic TIMER1_OVERFLOW,
  output logic RX_CLOCK_PULSE,
  output logic TX_CLOCK_PULSE,
  // Interrupt request.
  output logic TIMER_IRQ
);

  tcr_timing_if tim ();

  tcr_state_t s;
  tcr_state_t next_s;

  logic rx_sel;
  logic tx_sel;
  logic baud;
  logic run;
  logic counter_sel;
  logic capture_sel;
  logic ext_enable;
  logic down_mode;
  logic tick;
  logic count_up;
  logic overflow;
  logic underflow;
  logic trig_event;
  logic wr_control;
  logic wr_mode;
  logic wr_cap_low;
  logic wr_cap_high;
  logic wr_count_low;
  logic wr_count_high;

  // ---------------------------------------------------------------
  // Timing and pin sampling
  // ---------------------------------------------------------------
  tcr_phase_gen u_phase (
    .clk(CLK),
    .resetn(RESETN),
    .tim(tim.gen)
  );

  tcr_pin_sampler u_pins (
    .clk(CLK),
    .resetn(RESETN),
    .count_pin(COUNT_PIN),
    .trigger_pin(TRIGGER_PIN),
    .tim(tim.pins)
  );

  // ---------------------------------------------------------------
  // Control decode
  // ---------------------------------------------------------------
  always_comb begin
    rx_sel = s.control[BIT_RX_CLOCK];
    tx_sel = s.control[BIT_TX_CLOCK];
    baud = rx_sel | tx_sel;
    run = s.control[BIT_RUN];
    counter_sel = s.control[BIT_COUNTER_SEL];
    capture_sel = s.control[BIT_CAPTURE_SEL] & ~baud;
    ext_enable = s.control[BIT_EXT_ENABLE];
    down_mode = s.down_enable & ~baud & ~capture_sel;
  end

  // ---------------------------------------------------------------
  // Count tick selection
  // ---------------------------------------------------------------
  always_comb begin
    if (!run) begin
      tick = 1'b0;
    end else if (counter_sel) begin
      tick = s.pending & tim.update_strobe;
    end else if (baud) begin
      tick = tim.state_strobe;
    end else begin
      tick = tim.update_strobe;
    end
    count_up = ~down_mode | tim.trig_level;
    overflow = tick & count_up & (s.count == COUNT_TOP);
    underflow = tick & ~count_up & (s.count == s.capture);
    trig_event = tim.trig_fall & ext_enable & ~down_mode;
  end

  // ---------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_control = SFR_WE & (SFR_ADDR == ADDR_CONTROL);
    wr_mode = SFR_WE & (SFR_ADDR == ADDR_MODE);
    wr_cap_low = SFR_WE & (SFR_ADDR == ADDR_CAP_LOW);
    wr_cap_high = SFR_WE & (SFR_ADDR == ADDR_CAP_HIGH);
    wr_count_low = SFR_WE & (SFR_ADDR == ADDR_COUNT_LOW);
    wr_count_high = SFR_WE & (SFR_ADDR == ADDR_COUNT_HIGH);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;

    if (tim.count_fall) begin
      next_s.pending = 1'b1;
    end else if (tim.update_strobe) begin
      next_s.pending = 1'b0;
    end

    if (tick) begin
      if (overflow) begin
        if (capture_sel) begin
          next_s.count = COUNT_ZERO;
        end else begin
          next_s.count = s.capture;
        end
      end else if (underflow) begin
        next_s.count = COUNT_TOP;
      end else if (count_up) begin
        next_s.count = s.count + COUNT_ONE;
      end else begin
        next_s.count = s.count - COUNT_ONE;
      end
    end

    if (trig_event && !baud) begin
      if (capture_sel) begin
        next_s.capture = s.count;
      end else begin
        next_s.count = s.capture;
      end
    end

    if (wr_count_low) begin
      next_s.count[7:0] = SFR_WDATA;
    end
    if (wr_count_high) begin
      next_s.count[15:8] = SFR_WDATA;
    end
    if (wr_cap_low) begin
      next_s.capture[7:0] = SFR_WDATA;
    end
    if (wr_cap_high) begin
      next_s.capture[15:8] = SFR_WDATA;
    end
    if (wr_mode) begin
      next_s.out_enable = SFR_WDATA[BIT_OUT_ENABLE];
      next_s.down_enable = SFR_WDATA[BIT_DOWN_ENABLE];
    end
    if (wr_control) begin
      next_s.control = SFR_WDATA;
    end

    if ((overflow || underflow) && !baud) begin
      next_s.control[BIT_OVERFLOW] = 1'b1;
    end
    if (trig_event) begin
      next_s.control[BIT_EXTERNAL] = 1'b1;
    end else if (down_mode && (overflow || underflow)) begin
      next_s.control[BIT_EXTERNAL] = ~next_s.control[BIT_EXTERNAL];
    end

    next_s.irq = next_s.control[BIT_OVERFLOW]
      | (next_s.control[BIT_EXTERNAL] & ~next_s.down_enable);

    next_s.rx_pulse = rx_sel ? overflow : TIMER1_OVERFLOW;
    next_s.tx_pulse = tx_sel ? overflow : TIMER1_OVERFLOW;

    if (SFR_RE) begin
      case (SFR_ADDR)
        ADDR_CONTROL: next_s.rdata = s.control;
        ADDR_MODE: begin
          next_s.rdata = RESET_BYTE;
          next_s.rdata[BIT_OUT_ENABLE] = s.out_enable;
          next_s.rdata[BIT_DOWN_ENABLE] = s.down_enable;
        end
        ADDR_CAP_LOW: next_s.rdata = s.capture[7:0];
        ADDR_CAP_HIGH: next_s.rdata = s.capture[15:8];
        ADDR_COUNT_LOW: next_s.rdata = s.count[7:0];
        ADDR_COUNT_HIGH: next_s.rdata = s.count[15:8];
        default: next_s.rdata = RESET_BYTE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign SFR_RDATA = s.rdata;
  assign RX_CLOCK_PULSE = s.rx_pulse;
  assign TX_CLOCK_PULSE = s.tx_pulse;
  assign TIMER_IRQ = s.irq;

endmodule // tcr_timer

// ==== bench/tcr_far_model.sv ====
// Serial port model: counts baud pulses and makes timer one overflows.
`timescale 1ns/1ps
module tcr_far_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Baud pulses in, timer one overflow out.
  input wire logic rx_pulse,
  input wire logic tx_pulse,
  output logic t1_ovf,
  output int rx_n,
  output int tx_n
);
  logic [2:0] div;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div <= 3'h0;
      t1_ovf <= 1'b0;
      rx_n <= 0;
      tx_n <= 0;
    end else begin
      div <= div + 3'h1;
      t1_ovf <= (div == 3'h7);
      rx_n <= rx_n + int'(rx_pulse);
      tx_n <= tx_n + int'(tx_pulse);
    end
  end
endmodule // tcr_far_model

// ==== bench/tcr_timer_asserts.sv ====
// Port checker for the timer two block.
`timescale 1ns/1ps
module tcr_timer_asserts
  import tcr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESETN,
  // Register bus.
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  input wire logic [7:0] SFR_RDATA,
  // Pins and serial clocking.
  input wire logic COUNT_PIN,
  input wire logic TRIGGER_PIN,
  input wire logic TIMER1_OVERFLOW,
  input wire logic RX_CLOCK_PULSE,
  input wire logic TX_CLOCK_PULSE,
  input wire logic TIMER_IRQ
);
  logic [2:0] ctl;
  logic wr_c;
  logic wr_ctl;
  assign wr_c = SFR_WE && SFR_ADDR == ADDR_CONTROL;
  assign wr_ctl = wr_c || (SFR_WE && SFR_ADDR == ADDR_MODE);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl <= 3'h0;
    end else if (wr_c) begin
      ctl <= SFR_WDATA[BIT_RX_CLOCK:BIT_EXT_ENABLE];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_rx_timer_one: assert property (!wr_c && !ctl[2] |=>
    RX_CLOCK_PULSE == $past(TIMER1_OVERFLOW)) else $error("rx clock");
  a_tx_timer_one: assert property (!wr_c && !ctl[1] |=>
    TX_CLOCK_PULSE == $past(TIMER1_OVERFLOW)) else $error("tx clock");
  a_baud_no_irq: assert property (ctl[2:1] != 2'h0 && !ctl[0]
    && !wr_ctl && !TIMER_IRQ |=> !TIMER_IRQ) else $error("baud irq");
  a_unmapped_zero: assert property (SFR_RE &&
    !(SFR_ADDR inside {[ADDR_CONTROL:ADDR_COUNT_HIGH]}) |=>
    SFR_RDATA == RESET_BYTE) else $error("unmapped read");
  a_rdata_hold: assert property (!SFR_RE |=> $stable(SFR_RDATA))
    else $error("read data moved");
  a_mode_reserved: assert property (SFR_RE && SFR_ADDR == ADDR_MODE
    |=> SFR_RDATA[7:2] == 6'h00) else $error("mode bits");
  a_irq_sticky: assert property (TIMER_IRQ && !wr_ctl &&
    !$past(wr_ctl) |=> TIMER_IRQ) else $error("irq dropped");
  a_ctl_readback: assert property (wr_c ##1 !SFR_WE && !SFR_RE
    ##1 SFR_RE && !SFR_WE && SFR_ADDR == ADDR_CONTROL |=>
    SFR_RDATA[5:0] == $past(SFR_WDATA[5:0], 3)) else $error("control");
endmodule // tcr_timer_asserts

bind tcr_timer tcr_timer_asserts u_tcr_timer_asserts (.CLK(CLK),
  .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
  .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA),
  .COUNT_PIN(COUNT_PIN), .TRIGGER_PIN(TRIGGER_PIN),
  .TIMER1_OVERFLOW(TIMER1_OVERFLOW), .RX_CLOCK_PULSE(RX_CLOCK_PULSE),
  .TX_CLOCK_PULSE(TX_CLOCK_PULSE), .TIMER_IRQ(TIMER_IRQ));

// ==== bench/tcr_timer_tb.sv ====
// Register-level testbench for the timer two block.
`timescale 1ns/1ps
module tcr_timer_tb;
  import tcr_pkg::*;
  logic CLK, RESETN, SFR_WE, SFR_RE, COUNT_PIN, TRIGGER_PIN, T1;
  logic RX, TX, IRQ;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, a;
  int failures, n_tests, rx_n, tx_n, n, r0, t0;
  tcr_timer u_tcr_timer (.CLK(CLK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE),
    .SFR_RDATA(SFR_RDATA), .COUNT_PIN(COUNT_PIN), .TRIGGER_PIN(TRIGGER_PIN),
    .TIMER1_OVERFLOW(T1), .RX_CLOCK_PULSE(RX), .TX_CLOCK_PULSE(TX),
    .TIMER_IRQ(IRQ));
  tcr_far_model u_tcr_far_model (.clk(CLK), .resetn(RESETN), .rx_pulse(RX),
    .tx_pulse(TX), .t1_ovf(T1), .rx_n(rx_n), .tx_n(tx_n));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] ad,
    input logic [7:0] d);
    SFR_WE <= we;
    SFR_RE <= !we;
    SFR_ADDR <= ad;
    SFR_WDATA <= d;
    @(posedge CLK);
    SFR_WE <= 1'b0;
    SFR_RE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    bus(1'b1, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    bus(1'b0, ad, 8'h00);
    chk(SFR_RDATA, e);
  endtask
  task automatic pin(input logic c, input logic t);
    COUNT_PIN <= c;
    TRIGGER_PIN <= t;
    repeat (2 * OSC_PER_CYCLE) @(posedge CLK);
  endtask
  task automatic wirq;
    n = 0;
    while (IRQ !== 1'b1 && n < 200) begin
      @(negedge CLK);
      n++;
    end
    chk(8'(IRQ), 8'h01);
    @(posedge CLK);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    conclude();
  end
  initial begin
    {RESETN, SFR_WE, SFR_RE, SFR_ADDR, SFR_WDATA} = '0;
    {COUNT_PIN, TRIGGER_PIN, failures, n_tests} = '1;
    failures = 0;
    n_tests = 0;
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    for (a = 8'hC7; a != 8'hCF; a++) rd(a, RESET_BYTE);
    r0 = rx_n;
    t0 = tx_n;
    repeat (64) @(posedge CLK);
    chk(8'(rx_n - r0), 8'h08);
    chk(8'(tx_n - t0), 8'h08);
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_CAP_LOW, 8'hFD);
    wr(ADDR_CAP_HIGH, 8'hFF);
    rd(ADDR_CAP_LOW, 8'hFD);
    rd(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_CONTROL, 8'h04);
    rd(ADDR_CONTROL, 8'h04);
    wirq();
    wr(ADDR_CONTROL, 8'h04);
    wirq();
    chk(8'(n inside {[3*OSC_PER_CYCLE-4:3*OSC_PER_CYCLE]}), 8'h01);
    wr(ADDR_CONTROL, 8'h80);
    repeat (30) @(posedge CLK);
    rd(ADDR_COUNT_LOW, 8'hFD);
    rd(ADDR_CONTROL, 8'h80);
    chk(8'(IRQ), 8'h01);
    wr(ADDR_CONTROL, 8'h34);
    r0 = rx_n;
    t0 = tx_n;
    repeat (60) @(posedge CLK);
    chk(8'(IRQ), 8'h00);
    chk(8'(rx_n - r0 inside {[9:11]}), 8'h01);
    chk(8'(tx_n - t0 inside {[9:11]}), 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h06);
    repeat (5) begin
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b1);
    end
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW, 8'h05);
    wr(ADDR_COUNT_LOW, 8'hCD);
    wr(ADDR_COUNT_HIGH, 8'hAB);
    wr(ADDR_CONTROL, 8'h09);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    rd(ADDR_CAP_LOW, 8'hCD);
    rd(ADDR_CAP_HIGH, 8'hAB);
    rd(ADDR_CONTROL, 8'h49);
    chk(8'(IRQ), 8'h01);
    wr(ADDR_CONTROL, 8'h01);
    wr(ADDR_CAP_LOW, 8'h00);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    rd(ADDR_CAP_LOW, 8'h00);
    wr(ADDR_CAP_LOW, 8'h66);
    wr(ADDR_CAP_HIGH, 8'h55);
    wr(ADDR_CONTROL, 8'h08);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    rd(ADDR_COUNT_LOW, 8'h66);
    rd(ADDR_CONTROL, 8'h48);
    wr(ADDR_MODE, 8'h01);
    chk(8'(IRQ), 8'h00);
    rd(ADDR_MODE, 8'h01);
    pin(1'b1, 1'b0);
    wr(ADDR_COUNT_LOW, 8'h03);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CAP_LOW, 8'h01);
    wr(ADDR_CAP_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h04);
    wirq();
    rd(ADDR_CONTROL, 8'hC4);
    wr(ADDR_CONTROL, 8'h80);
    rd(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_CONTROL, 8'h05);
    wirq();
    rd(ADDR_CONTROL, 8'h85);
    wr(ADDR_CONTROL, 8'h01);
    rd(ADDR_COUNT_HIGH, 8'h00);
    rd(ADDR_COUNT_LOW, 8'h00);
    conclude();
  end
endmodule // tcr_timer_tb
